// ### logic/ssc_consts.vh
`ifndef SSC_CONSTS_VH
`define SSC_CONSTS_VH

// Register indices; the byte address is four times the index.
`define SSC_IDX_GAIN_AMP      6'h12
`define SSC_IDX_PREAMP        6'h13
`define SSC_IDX_CURRENT_REF   6'h16
`define SSC_IDX_REC_A_SEQ     6'h17
`define SSC_IDX_REC_B_SEQ     6'h18
`define SSC_IDX_REC_A_ORIG    6'h19
`define SSC_IDX_REC_B_ORIG    6'h1a
`define SSC_IDX_CONTROL       6'h1b
`define SSC_IDX_STATUS        6'h1c

// Reset values.
`define SSC_RST_GAIN_AMP      16'h0077
`define SSC_RST_PREAMP        16'h0077
`define SSC_RST_CURRENT_REF   16'h0777
`define SSC_RST_CAPTURE_SEQ   16'h0000
`define SSC_RST_READ_ORIGIN   16'h0000

// Writable bits and bits that always read back as a fixed pattern.
`define SSC_MASK_GAIN_AMP     16'h00ff
`define SSC_MASK_PREAMP       16'h00ff
`define SSC_MASK_CURRENT_REF  16'h1f00
`define SSC_FIXED_CURRENT_REF 16'h0077

// Field positions.
`define SSC_BIAS_A_LSB        0
`define SSC_BIAS_B_LSB        4
`define SSC_PRECHARGE_LSB     8
`define SSC_IREF_SEL_BIT      12
`define SSC_COUNT_LSB         0
`define SSC_BLANK_FIRST_LSB   8
`define SSC_BLANK_PERIOD_LSB  12
`define SSC_COLUMN_LSB        0
`define SSC_LINE_LSB          8

// Control and status bits.
`define SSC_CTRL_START        0
`define SSC_CTRL_STOP         1
`define SSC_CTRL_RECORD       2
`define SSC_STAT_BUSY         0
`define SSC_STAT_RECORD       1
`define SSC_STAT_VALID        2
`define SSC_STAT_DONE_LSB     8

// Frame count that never ends, and the origin scale of 8.
`define SSC_ENDLESS_COUNT     8'h80
`define SSC_ORIGIN_SHIFT      3

`endif

// ### logic/ssc_regs.v
`timescale 1ns/100ps
`default_nettype none
`include "ssc_consts.vh"

module ssc_regs (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Frame timing from the readout generator
  input  wire        frame_tick,
  // Analog core controls
  output reg  [3:0]  active_gain_amp_bias,
  output reg  [3:0]  active_preamp_bias,
  output reg  [3:0]  precharge_bias,
  output reg         current_ref_source_sel,
  // Readout origin
  output reg  [10:0] first_column_addr,
  output reg  [10:0] first_line_addr,
  // Sequencer state
  output wire        acq_busy,
  output reg         frame_valid,
  output reg         active_record
);

  localparam ST_IDLE  = 4'b0001;
  localparam ST_BLANK = 4'b0010;
  localparam ST_LIVE  = 4'b0100;
  localparam ST_DRAIN = 4'b1000;

  reg [15:0] gain_amp_bias;
  reg [15:0] preamp_bias;
  reg [15:0] current_ref_bias;
  reg [15:0] rec_a_capture_seq;
  reg [15:0] rec_b_capture_seq;
  reg [15:0] rec_a_read_origin;
  reg [15:0] rec_b_read_origin;
  reg        ctrl_record;
  reg        run_record;
  reg [3:0]  state;
  reg [3:0]  next_state;
  reg [3:0]  blank_left;
  reg [3:0]  next_blank_left;
  reg [7:0]  delivered;
  reg [7:0]  next_delivered;
  reg        next_frame_valid;
  reg [15:0] rd_word;
  reg        seq_busy;

  function reg_hit;
    input [7:0] addr;
    input [5:0] idx;
    begin
      reg_hit = (addr == {idx, 2'b00});
    end
  endfunction

  function is_mapped;
    input [7:0] addr;
    begin
      is_mapped = reg_hit(addr, `SSC_IDX_GAIN_AMP) |
                  reg_hit(addr, `SSC_IDX_PREAMP) |
                  reg_hit(addr, `SSC_IDX_CURRENT_REF) |
                  reg_hit(addr, `SSC_IDX_REC_A_SEQ) |
                  reg_hit(addr, `SSC_IDX_REC_B_SEQ) |
                  reg_hit(addr, `SSC_IDX_REC_A_ORIG) |
                  reg_hit(addr, `SSC_IDX_REC_B_ORIG) |
                  reg_hit(addr, `SSC_IDX_CONTROL) |
                  reg_hit(addr, `SSC_IDX_STATUS);
    end
  endfunction

  wire wr_en     = psel & penable & pwrite;
  wire rd_setup  = psel & ~penable & ~pwrite;
  wire ctrl_wr   = wr_en & reg_hit(paddr, `SSC_IDX_CONTROL);
  wire start_req = ctrl_wr & pwdata[`SSC_CTRL_START];
  wire stop_req  = ctrl_wr & pwdata[`SSC_CTRL_STOP];

  // Zero wait states; read data is fetched during the setup cycle.
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign acq_busy = seq_busy;

  wire        sel_rec  = state[0] ? ctrl_record : run_record;
  wire [15:0] act_seq  = sel_rec ? rec_b_capture_seq : rec_a_capture_seq;
  wire [15:0] act_orig = sel_rec ? rec_b_read_origin : rec_a_read_origin;
  wire [7:0]  act_count = act_seq[`SSC_COUNT_LSB +: 8];
  wire [3:0]  act_gap   = act_seq[`SSC_BLANK_PERIOD_LSB +: 4];
  wire [7:0]  done_inc  = delivered + 8'h01;

  // Started record fields.
  // The select register is written at the same edge, so it is still stale.
  wire        start_rec   = pwdata[`SSC_CTRL_RECORD];
  wire [15:0] start_seq   = start_rec ? rec_b_capture_seq :
                                        rec_a_capture_seq;
  wire [3:0]  start_first = start_seq[`SSC_BLANK_FIRST_LSB +: 4];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gain_amp_bias     <= `SSC_RST_GAIN_AMP;
      preamp_bias       <= `SSC_RST_PREAMP;
      current_ref_bias  <= `SSC_RST_CURRENT_REF;
      rec_a_capture_seq <= `SSC_RST_CAPTURE_SEQ;
      rec_b_capture_seq <= `SSC_RST_CAPTURE_SEQ;
      rec_a_read_origin <= `SSC_RST_READ_ORIGIN;
      rec_b_read_origin <= `SSC_RST_READ_ORIGIN;
      ctrl_record       <= 1'b0;
    end else if (wr_en) begin
      if (reg_hit(paddr, `SSC_IDX_GAIN_AMP)) begin
        gain_amp_bias <= pwdata[15:0] & `SSC_MASK_GAIN_AMP;
      end
      if (reg_hit(paddr, `SSC_IDX_PREAMP)) begin
        preamp_bias <= pwdata[15:0] & `SSC_MASK_PREAMP;
      end
      if (reg_hit(paddr, `SSC_IDX_CURRENT_REF)) begin
        current_ref_bias <= (pwdata[15:0] & `SSC_MASK_CURRENT_REF) |
                            `SSC_FIXED_CURRENT_REF;
      end
      if (reg_hit(paddr, `SSC_IDX_REC_A_SEQ)) begin
        rec_a_capture_seq <= pwdata[15:0];
      end
      if (reg_hit(paddr, `SSC_IDX_REC_B_SEQ)) begin
        rec_b_capture_seq <= pwdata[15:0];
      end
      if (reg_hit(paddr, `SSC_IDX_REC_A_ORIG)) begin
        rec_a_read_origin <= pwdata[15:0];
      end
      if (reg_hit(paddr, `SSC_IDX_REC_B_ORIG)) begin
        rec_b_read_origin <= pwdata[15:0];
      end
      if (ctrl_wr) begin
        ctrl_record <= pwdata[`SSC_CTRL_RECORD];
      end
    end
  end

  always @* begin
    rd_word = 16'h0000;
    if (reg_hit(paddr, `SSC_IDX_GAIN_AMP)) begin
      rd_word = gain_amp_bias;
    end else if (reg_hit(paddr, `SSC_IDX_PREAMP)) begin
      rd_word = preamp_bias;
    end else if (reg_hit(paddr, `SSC_IDX_CURRENT_REF)) begin
      rd_word = current_ref_bias;
    end else if (reg_hit(paddr, `SSC_IDX_REC_A_SEQ)) begin
      rd_word = rec_a_capture_seq;
    end else if (reg_hit(paddr, `SSC_IDX_REC_B_SEQ)) begin
      rd_word = rec_b_capture_seq;
    end else if (reg_hit(paddr, `SSC_IDX_REC_A_ORIG)) begin
      rd_word = rec_a_read_origin;
    end else if (reg_hit(paddr, `SSC_IDX_REC_B_ORIG)) begin
      rd_word = rec_b_read_origin;
    end else if (reg_hit(paddr, `SSC_IDX_CONTROL)) begin
      rd_word[`SSC_CTRL_RECORD] = ctrl_record;
    end else if (reg_hit(paddr, `SSC_IDX_STATUS)) begin
      rd_word[`SSC_STAT_BUSY]   = acq_busy;
      rd_word[`SSC_STAT_RECORD] = active_record;
      rd_word[`SSC_STAT_VALID]  = frame_valid;
      rd_word[`SSC_STAT_DONE_LSB +: 8] = delivered;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= {16'h0000, rd_word};
    end
  end

  // The sequencer advances once per frame_tick, which marks a frame start.
  always @* begin
    next_state       = state;
    next_blank_left  = blank_left;
    next_delivered   = delivered;
    next_frame_valid = frame_valid;
    if (stop_req) begin
      next_state       = ST_IDLE;
      next_frame_valid = 1'b0;
    end else if (start_req) begin
      next_blank_left  = start_first;
      next_delivered   = 8'h00;
      next_frame_valid = 1'b0;
      next_state       = (start_first == 4'h0) ? ST_LIVE : ST_BLANK;
    end else if (frame_tick) begin
      case (state)
        ST_IDLE: begin
          next_frame_valid = 1'b0;
        end
        ST_BLANK: begin
          next_frame_valid = 1'b0;
          next_blank_left  = blank_left - 4'h1;
          if (blank_left == 4'h1) begin
            next_state = ST_LIVE;
          end
        end
        ST_LIVE: begin
          next_frame_valid = 1'b1;
          next_delivered   = done_inc;
          if (act_count != `SSC_ENDLESS_COUNT && done_inc == act_count) begin
            next_state = ST_DRAIN;
          end else if (act_gap != 4'h0) begin
            next_blank_left = act_gap;
            next_state      = ST_BLANK;
          end
        end
        ST_DRAIN: begin
          next_frame_valid = 1'b0;
          next_state       = ST_IDLE;
        end
        default: begin
          next_frame_valid = 1'b0;
          next_state       = ST_IDLE;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state       <= ST_IDLE;
      blank_left  <= 4'h0;
      delivered   <= 8'h00;
      frame_valid <= 1'b0;
      run_record  <= 1'b0;
      seq_busy    <= 1'b0;
    end else begin
      state       <= next_state;
      blank_left  <= next_blank_left;
      delivered   <= next_delivered;
      frame_valid <= next_frame_valid;
      seq_busy    <= ~next_state[0];
      if (start_req && !stop_req) begin
        run_record <= start_rec;
      end
    end
  end

  // Outputs are registered so the analog controls never glitch.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_gain_amp_bias   <= 4'h0;
      active_preamp_bias     <= 4'h0;
      precharge_bias         <= 4'h0;
      current_ref_source_sel <= 1'b0;
      first_column_addr      <= 11'h000;
      first_line_addr        <= 11'h000;
      active_record          <= 1'b0;
    end else begin
      active_record <= sel_rec;
      if (sel_rec) begin
        active_gain_amp_bias <= gain_amp_bias[`SSC_BIAS_B_LSB +: 4];
        active_preamp_bias   <= preamp_bias[`SSC_BIAS_B_LSB +: 4];
      end else begin
        active_gain_amp_bias <= gain_amp_bias[`SSC_BIAS_A_LSB +: 4];
        active_preamp_bias   <= preamp_bias[`SSC_BIAS_A_LSB +: 4];
      end
      precharge_bias         <= current_ref_bias[`SSC_PRECHARGE_LSB +: 4];
      current_ref_source_sel <= current_ref_bias[`SSC_IREF_SEL_BIT];
      first_column_addr <= {act_orig[`SSC_COLUMN_LSB +: 8],
                            {`SSC_ORIGIN_SHIFT{1'b0}}};
      first_line_addr   <= {act_orig[`SSC_LINE_LSB +: 8],
                            {`SSC_ORIGIN_SHIFT{1'b0}}};
    end
  end

endmodule

`default_nettype wire

// ### verification/ssc_regs_props.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_consts.vh"
module ssc_props (
  // Bus
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  // Sequencer
  input wire logic        frame_tick,
  input wire logic [10:0] first_column_addr,
  input wire logic [10:0] first_line_addr,
  input wire logic        acq_busy,
  input wire logic        frame_valid,
  input wire logic        active_record
);
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pwrite
                   && paddr == {`SSC_IDX_CONTROL, 2'b00};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_rd(logic [5:0] i);
    psel && penable && !pwrite && paddr == {i, 2'b00};
  endsequence
  sequence s_start;
    ctrl_wr && pwdata[0] && !pwdata[1];
  endsequence
  property p_gain_fix; s_rd(`SSC_IDX_GAIN_AMP) |-> prdata[15:8] == 8'h00;
  endproperty
  a_gain_fix: assert property (p_gain_fix) else $error("gain upper set");
  property p_pre_fix; s_rd(`SSC_IDX_PREAMP) |-> prdata[15:8] == 8'h00;
  endproperty
  a_pre_fix: assert property (p_pre_fix) else $error("preamp upper set");
  property p_iref_fix;
    s_rd(`SSC_IDX_CURRENT_REF) |-> prdata[7:0] == 8'h77;
  endproperty
  a_iref_fix: assert property (p_iref_fix) else $error("iref low bad");
  property p_col; first_column_addr[2:0] == 3'h0; endproperty
  a_col: assert property (p_col) else $error("column not times 8");
  property p_line; first_line_addr[2:0] == 3'h0; endproperty
  a_line: assert property (p_line) else $error("line not times 8");
  property p_start; s_start |=> acq_busy; endproperty
  a_start: assert property (p_start) else $error("start missed");
  property p_valid_cause;
    $changed(frame_valid) |-> $past(frame_tick) || $past(ctrl_wr);
  endproperty
  a_valid_cause: assert property (p_valid_cause) else $error("valid moved");
  property p_valid_busy; frame_valid |-> acq_busy; endproperty
  a_valid_busy: assert property (p_valid_busy) else $error("valid idle");
  property p_rec_hold;
    acq_busy && $past(acq_busy) && !$past(ctrl_wr) && !$past(ctrl_wr, 2)
      |-> $stable(active_record);
  endproperty
  a_rec_hold: assert property (p_rec_hold) else $error("record moved");
endmodule
bind ssc_regs ssc_props u_props (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .frame_tick(frame_tick), .first_column_addr(first_column_addr),
  .first_line_addr(first_line_addr), .acq_busy(acq_busy),
  .frame_valid(frame_valid), .active_record(active_record)
);
`default_nettype wire

// ### verification/ssc_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ssc_consts.vh"
module ssc_regs_tb_top;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
  logic        pwrite = 0, frame_tick = 0;
  logic [7:0]  paddr = 0, x, y;
  logic [31:0] pwdata = 0;
  wire  [31:0] prdata;
  wire         pready, pslverr, sel, busy, fval, rec;
  wire  [3:0]  gain, pre, prech;
  wire  [10:0] col, line;
  int          mismatches = 0, checked = 0, cyc = 0, seed = 96;
  logic [32:0] q[$];
  always #5 pclk = ~pclk;
  ssc_regs dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .frame_tick(frame_tick),
    .active_gain_amp_bias(gain), .active_preamp_bias(pre),
    .precharge_bias(prech), .current_ref_source_sel(sel),
    .first_column_addr(col), .first_line_addr(line),
    .acq_busy(busy), .frame_valid(fval), .active_record(rec)
  );
  task automatic close_out;
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [32:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // The request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [5:0] i,
                     input logic [15:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= {16'h0, d};
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [32:0] e);
    q.push_back(e);
    apb(0, i, 16'h0);
  endtask
  task automatic tick(input logic v, b);
    @(posedge pclk) frame_tick <= 1;
    @(posedge pclk) frame_tick <= 0;
    @(posedge pclk);
    chk("frame_valid", v, fval);
    chk("acq_busy", b, busy);
  endtask
  // Read results are paired with the oldest expectation as they appear.
  always @(posedge pclk) begin
    if (psel && penable && !pwrite && pready)
      chk("prdata", q.pop_front(), {pslverr, prdata});
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 4000) begin
      mismatches++;
      close_out;
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    rd(`SSC_IDX_GAIN_AMP, 33'h77);
    rd(`SSC_IDX_PREAMP, 33'h77);
    rd(`SSC_IDX_CURRENT_REF, 33'h777);
    rd(`SSC_IDX_REC_A_SEQ, 33'h0);
    rd(`SSC_IDX_REC_B_SEQ, 33'h0);
    rd(`SSC_IDX_REC_B_ORIG, 33'h0);
    chk("precharge_bias", 33'h7, prech);
    apb(1, `SSC_IDX_GAIN_AMP, 16'hff73);
    rd(`SSC_IDX_GAIN_AMP, 33'h73);
    apb(1, `SSC_IDX_PREAMP, 16'hff37);
    rd(`SSC_IDX_PREAMP, 33'h37);
    apb(1, `SSC_IDX_CURRENT_REF, 16'hffff);
    rd(`SSC_IDX_CURRENT_REF, 33'h1f77);
    rd(6'h00, 33'h1_0000_0000);
    x = 8'($random(seed));
    y = 8'($random(seed));
    apb(1, `SSC_IDX_REC_A_ORIG, {y, x});
    apb(1, `SSC_IDX_REC_B_ORIG, {x, y});
    rd(`SSC_IDX_REC_A_ORIG, {17'h0, y, x});
    apb(1, `SSC_IDX_REC_A_SEQ, 16'h1102);
    apb(1, `SSC_IDX_REC_B_SEQ, 16'h0080);
    rd(`SSC_IDX_REC_A_SEQ, 33'h1102);
    chk("gain", 33'h3, gain);
    chk("preamp", 33'h7, pre);
    chk("precharge", 33'hf, prech);
    chk("iref_sel", 33'h1, sel);
    chk("column", {x, 3'h0}, col);
    chk("line", {y, 3'h0}, line);
    apb(1, `SSC_IDX_CONTROL, 16'h0001);
    tick(0, 1);
    tick(1, 1);
    tick(0, 1);
    tick(1, 1);
    tick(0, 0);
    rd(`SSC_IDX_STATUS, 33'h0200);
    apb(1, `SSC_IDX_CONTROL, 16'h0005);
    repeat (2) @(posedge pclk);
    chk("record", 33'h1, rec);
    chk("gain", 33'h7, gain);
    chk("preamp", 33'h3, pre);
    chk("column", {y, 3'h0}, col);
    chk("line", {x, 3'h0}, line);
    repeat (5) tick(1, 1);
    apb(1, `SSC_IDX_CONTROL, 16'h0002);
    repeat (2) @(posedge pclk);
    chk("acq_busy", 33'h0, busy);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk("gain", 33'h0, gain);
    presetn <= 1;
    rd(`SSC_IDX_GAIN_AMP, 33'h77);
    rd(`SSC_IDX_REC_A_SEQ, 33'h0);
    rd(`SSC_IDX_REC_B_ORIG, 33'h0);
    chk("gain", 33'h7, gain);
    chk("precharge", 33'h7, prech);
    chk("iref_sel", 33'h0, sel);
    close_out;
  end
endmodule
`default_nettype wire
